/* logic/vorcd_params.svh */
`ifndef VORCD_PARAMS_SVH
`define VORCD_PARAMS_SVH
// Register byte offsets
`define VORCD_ROUTE_OFS 12'h000
`define VORCD_VCTRL_OFS 12'h004
`define VORCD_FMT_OFS 12'h008
`define VORCD_STAT_OFS 12'h00c
// Route register: output i source at [4*i+2:4*i]
`define VORCD_ROUTE_STRIDE 4
`define VORCD_ROUTE_RST 32'h0000_0000
// Video control fields
`define VORCD_DITH_LSB 0
`define VORCD_CLIPB_BIT 4
`define VORCD_CLIPW_BIT 5
`define VORCD_REFSEL_LSB 8
// Status fields
`define VORCD_ST_FMT_LSB 0
`define VORCD_ST_OK_BIT 4
`define VORCD_ST_DIRTY_BIT 8
`define VORCD_ST_REF_LSB 12
// Sample levels, 10-bit video
`define VORCD_BLACK 10'h040
`define VORCD_WHITE 10'h3ac
`define VORCD_LEGAL_MIN 10'h004
`define VORCD_LEGAL_MAX 10'h3fb
// Dither noise source
`define VORCD_LFSR_SEED 16'hace1
// Non-volatile commit delay
`define VORCD_SAVE_S 30
`define VORCD_CLK_HZ 125000000
`define VORCD_FIFO_DEPTH 8
`endif

/* logic/vorcd_pkg.sv */
`default_nettype none
package vorcd_pkg;
  typedef enum logic [2:0] {VORCD_QUAD, VORCD_BKGD_A, VORCD_BKGD_B, VORCD_BKGD_C, VORCD_BKGD_D} vorcd_src_t;
  typedef enum logic [1:0] {VORCD_DITH_OFF, VORCD_DITH_LOW, VORCD_DITH_MED, VORCD_DITH_HIGH} vorcd_dith_t;
  typedef enum logic [1:0] {VORCD_REF_FRAME1, VORCD_REF_FRAME2, VORCD_REF_EXT} vorcd_ref_t;
  typedef enum logic [2:0] {
    VORCD_F480I_5994, VORCD_F720P_5994, VORCD_F1080I_5994, VORCD_F576I_50,
    VORCD_F720P_50, VORCD_F1080I_50, VORCD_F1080SF_2398, VORCD_F1080SF_24
  } vorcd_fmt_t;
  typedef struct packed {
    logic anc;
    logic [9:0] data;
  } vorcd_smp_t;
  typedef struct packed {
    vorcd_smp_t quad;
    vorcd_smp_t [3:0] bkgd;
  } vorcd_bundle_t;
endpackage
`default_nettype wire

/* logic/vorcd_top.sv */
`include "vorcd_params.svh"
`default_nettype none

// Input sample FIFO, width and depth shape the storage
module vorcd_fifo #(
  parameter int W = 55,
  parameter int D = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  // Pointer and fill bookkeeping
  always_comb begin
    push = wr_valid && wr_ready;
    pop = rd_valid && rd_ready;
    wp_d = push ? ((wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d = pop ? ((rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  // Storage has no reset, only written words are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end
  assign wr_ready = (cnt_q != (AW+1)'(D));
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem_q[rp_q];
endmodule // vorcd_fifo

module vorcd_top #(
  parameter logic [31:0] SAVE_CYC = 32'(64'(`VORCD_SAVE_S) * 64'(`VORCD_CLK_HZ))
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire vorcd_pkg::vorcd_bundle_t in_data,
  input wire logic [2:0] ref_pulse,
  input wire logic [2:0][2:0] ref_fmt,
  output logic out_valid,
  input wire logic out_ready,
  output vorcd_pkg::vorcd_smp_t [3:0] out_data,
  output logic frame_start,
  output vorcd_pkg::vorcd_fmt_t out_fmt,
  output logic fmt_ok,
  output logic nv_save
);
  // Register state
  logic [31:0] route_q, route_d;
  vorcd_pkg::vorcd_dith_t dith_q, dith_d;
  logic clipb_q, clipb_d, clipw_q, clipw_d;
  vorcd_pkg::vorcd_ref_t refsel_q, refsel_d;
  vorcd_pkg::vorcd_fmt_t fmt_req_q, fmt_req_d, fmt_act_q, fmt_act_d;
  logic [31:0] rdata, prdata_q, prdata_d;
  logic acc, wr_en, mapped;
  // Commit timer state
  logic dirty_q, dirty_d, save_q, save_d;
  logic [31:0] tmr_q, tmr_d;
  // Video path state
  vorcd_pkg::vorcd_bundle_t f_data;
  logic f_valid, f_ready;
  vorcd_pkg::vorcd_smp_t [3:0] od_q, od_d;
  logic ov_q, ov_d, fs_q, fs_d;
  logic [15:0] lfsr_q, lfsr_d;
  vorcd_pkg::vorcd_fmt_t ref_now;
  logic ok_now;
  // Reference format compatibility table
  function automatic logic compat(vorcd_pkg::vorcd_fmt_t r, vorcd_pkg::vorcd_fmt_t o);
    logic ok;
    ok = 1'b0;
    unique case (r)
      vorcd_pkg::VORCD_F480I_5994, vorcd_pkg::VORCD_F1080I_5994: begin
        ok = (o == vorcd_pkg::VORCD_F480I_5994) || (o == vorcd_pkg::VORCD_F720P_5994) ||
             (o == vorcd_pkg::VORCD_F1080I_5994);
      end
      vorcd_pkg::VORCD_F720P_5994: begin
        ok = (o == vorcd_pkg::VORCD_F720P_5994);
      end
      vorcd_pkg::VORCD_F576I_50, vorcd_pkg::VORCD_F1080I_50: begin
        ok = (o == vorcd_pkg::VORCD_F576I_50) || (o == vorcd_pkg::VORCD_F720P_50) ||
             (o == vorcd_pkg::VORCD_F1080I_50);
      end
      vorcd_pkg::VORCD_F720P_50, vorcd_pkg::VORCD_F1080SF_2398, vorcd_pkg::VORCD_F1080SF_24: begin
        ok = (o == r);
      end
    endcase
    return ok;
  endfunction
  // APB decode, zero wait states
  always_comb begin
    acc = psel && penable;
    mapped = (paddr == `VORCD_ROUTE_OFS) || (paddr == `VORCD_VCTRL_OFS) ||
             (paddr == `VORCD_FMT_OFS) || (paddr == `VORCD_STAT_OFS);
    wr_en = acc && pwrite && mapped;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `VORCD_ROUTE_OFS: rdata = route_q;
      `VORCD_VCTRL_OFS: begin
        rdata[`VORCD_DITH_LSB +: 2] = dith_q;
        rdata[`VORCD_CLIPB_BIT] = clipb_q;
        rdata[`VORCD_CLIPW_BIT] = clipw_q;
        rdata[`VORCD_REFSEL_LSB +: 2] = refsel_q;
      end
      `VORCD_FMT_OFS: rdata[2:0] = fmt_req_q;
      `VORCD_STAT_OFS: begin
        rdata[`VORCD_ST_FMT_LSB +: 3] = fmt_act_q;
        rdata[`VORCD_ST_OK_BIT] = ok_now;
        rdata[`VORCD_ST_DIRTY_BIT] = dirty_q;
        rdata[`VORCD_ST_REF_LSB +: 3] = ref_now;
      end
      default: rdata = 32'h0000_0000;
    endcase
    prdata_d = (psel && !penable && !pwrite) ? rdata : 32'h0000_0000; // Taken in setup, stands in access
  end
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;
  // Configuration writes; illegal codes leave a field as it was
  always_comb begin
    route_d = route_q;
    dith_d = dith_q;
    clipb_d = clipb_q;
    clipw_d = clipw_q;
    refsel_d = refsel_q;
    fmt_req_d = fmt_req_q;
    if (wr_en && paddr == `VORCD_ROUTE_OFS) begin
      for (int i = 0; i < 4; i++) begin
        if (pwdata[`VORCD_ROUTE_STRIDE*i +: 3] <= 3'(vorcd_pkg::VORCD_BKGD_D)) begin
          route_d[`VORCD_ROUTE_STRIDE*i +: 3] = pwdata[`VORCD_ROUTE_STRIDE*i +: 3];
        end
      end
    end
    if (wr_en && paddr == `VORCD_VCTRL_OFS) begin
      dith_d = vorcd_pkg::vorcd_dith_t'(pwdata[`VORCD_DITH_LSB +: 2]);
      clipb_d = pwdata[`VORCD_CLIPB_BIT];
      clipw_d = pwdata[`VORCD_CLIPW_BIT];
      if (pwdata[`VORCD_REFSEL_LSB +: 2] <= 2'(vorcd_pkg::VORCD_REF_EXT)) begin
        refsel_d = vorcd_pkg::vorcd_ref_t'(pwdata[`VORCD_REFSEL_LSB +: 2]);
      end
    end
    if (wr_en && paddr == `VORCD_FMT_OFS) begin
      fmt_req_d = vorcd_pkg::vorcd_fmt_t'(pwdata[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= `VORCD_ROUTE_RST;
      dith_q <= vorcd_pkg::VORCD_DITH_OFF;
      clipb_q <= 1'b0;
      clipw_q <= 1'b0;
      refsel_q <= vorcd_pkg::VORCD_REF_FRAME1;
      fmt_req_q <= vorcd_pkg::VORCD_F1080I_5994;
      prdata_q <= 32'h0000_0000;
    end else begin
      route_q <= route_d;
      dith_q <= dith_d;
      clipb_q <= clipb_d;
      clipw_q <= clipw_d;
      refsel_q <= refsel_d;
      fmt_req_q <= fmt_req_d;
      prdata_q <= prdata_d;
    end
  end
  // Reference pick and format gate; a refused format keeps the last legal one
  always_comb begin
    ref_now = vorcd_pkg::vorcd_fmt_t'(ref_fmt[refsel_q]);
    ok_now = compat(ref_now, fmt_req_q);
    fmt_act_d = ok_now ? fmt_req_q : fmt_act_q;
    fs_d = ref_pulse[refsel_q];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_act_q <= vorcd_pkg::VORCD_F1080I_5994;
      fs_q <= 1'b0;
    end else begin
      fmt_act_q <= fmt_act_d;
      fs_q <= fs_d;
    end
  end
  assign out_fmt = fmt_act_q;
  assign fmt_ok = ok_now;
  assign frame_start = fs_q;
  // Commit timer restarts on each write to the route, control or format word; a write in the save cycle keeps dirty set
  always_comb begin
    save_d = 1'b0;
    dirty_d = dirty_q;
    tmr_d = tmr_q;
    if (wr_en && paddr != `VORCD_STAT_OFS) begin
      dirty_d = 1'b1;
      tmr_d = SAVE_CYC - 32'h0000_0001;
    end else if (dirty_q) begin
      if (tmr_q == 32'h0000_0000) begin
        save_d = 1'b1;
        dirty_d = 1'b0;
      end else begin
        tmr_d = tmr_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dirty_q <= 1'b0;
      save_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
    end else begin
      dirty_q <= dirty_d;
      save_q <= save_d;
      tmr_q <= tmr_d;
    end
  end
  assign nv_save = save_q;
  // Input buffer, stalls the sources when the sink stalls
  vorcd_fifo #(
    .W($bits(vorcd_pkg::vorcd_bundle_t)),
    .D(`VORCD_FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data(in_data),
    .rd_valid(f_valid),
    .rd_ready(f_ready),
    .rd_data(f_data)
  );
  assign f_ready = !ov_q || out_ready;
  // Per-output select, dither and clip; noise slices differ per output
  always_comb begin
    vorcd_pkg::vorcd_smp_t s;
    logic [11:0] t, mask, half;
    logic [2:0] src;
    s = '0;
    t = '0;
    src = '0;
    mask = 12'h000;
    unique case (dith_q)
      vorcd_pkg::VORCD_DITH_OFF: mask = 12'h000;
      vorcd_pkg::VORCD_DITH_LOW: mask = 12'h003;
      vorcd_pkg::VORCD_DITH_MED: mask = 12'h007;
      vorcd_pkg::VORCD_DITH_HIGH: mask = 12'h00f;
    endcase
    half = mask >> 1;
    od_d = od_q;
    ov_d = ov_q && !out_ready;
    lfsr_d = lfsr_q;
    if (f_valid && f_ready) begin
      ov_d = 1'b1;
      lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      for (int i = 0; i < 4; i++) begin
        src = route_q[`VORCD_ROUTE_STRIDE*i +: 3];
        s = (src == 3'(vorcd_pkg::VORCD_QUAD)) ? f_data.quad : f_data.bkgd[src - 3'h1];
        if (s.anc) begin
          if (src == 3'(vorcd_pkg::VORCD_QUAD)) begin
            s.anc = 1'b0; // Composite has no ancillary space to carry
            s.data = `VORCD_BLACK;
          end
          od_d[i] = s;
        end else begin
          t = {2'b00, s.data} + ({8'h00, lfsr_q[4*i +: 4]} & mask);
          t = (t < half) ? 12'h000 : t - half;
          if (t < {2'b00, `VORCD_LEGAL_MIN}) begin
            t = {2'b00, `VORCD_LEGAL_MIN};
          end
          if (t > {2'b00, `VORCD_LEGAL_MAX}) begin
            t = {2'b00, `VORCD_LEGAL_MAX};
          end
          if (clipb_q && t < {2'b00, `VORCD_BLACK}) begin
            t = {2'b00, `VORCD_BLACK};
          end
          if (clipw_q && t > {2'b00, `VORCD_WHITE}) begin
            t = {2'b00, `VORCD_WHITE};
          end
          od_d[i] = '{anc: 1'b0, data: t[9:0]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_q <= '0;
      ov_q <= 1'b0;
      lfsr_q <= `VORCD_LFSR_SEED;
    end else begin
      od_q <= od_d;
      ov_q <= ov_d;
      lfsr_q <= lfsr_d;
    end
  end
  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule // vorcd_top
`default_nettype wire

/* dv/vorcd_props.sv */
`default_nettype none
// Port-level checks on the video output stage, frame start, format gate and commit timer
module vorcd_props #(
  parameter logic [31:0] SAVE_CYC = 32'd20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] ref_pulse,
  input wire logic [2:0][2:0] ref_fmt,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire vorcd_pkg::vorcd_smp_t [3:0] out_data,
  input wire logic frame_start,
  input wire vorcd_pkg::vorcd_fmt_t out_fmt,
  input wire logic fmt_ok,
  input wire logic nv_save
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr, cfg_wr, clipb_q, clipw_q, dirty_q, okb, okw, selp;
  logic [1:0] sel_q;
  logic [2:0] req_q;
  logic [31:0] cnt_q;
  assign wr = psel && penable && pwrite;
  assign cfg_wr = wr && paddr < 12'h00c;
  assign selp = ref_pulse[sel_q];
  function automatic logic compat(logic [2:0] r, logic [2:0] o);
    case (r)
      3'h0, 3'h2: return o < 3'h3;
      3'h3, 3'h5: return o > 3'h2 && o < 3'h6;
      default: return o == r;
    endcase
  endfunction
  // Shadow of settings; counter of cycles since the last config write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clipb_q, clipw_q, sel_q, dirty_q} <= '0;
      req_q <= 3'h2;
      cnt_q <= '0;
    end else begin
      if (wr && paddr == 12'h004) {clipw_q, clipb_q} <= pwdata[5:4];
      if (wr && paddr == 12'h004 && pwdata[9:8] != 2'h3) sel_q <= pwdata[9:8];
      if (wr && paddr == 12'h008) req_q <= pwdata[2:0];
      dirty_q <= cfg_wr || (dirty_q && !nv_save);
      cnt_q <= cfg_wr ? 32'h1 : cnt_q + 32'h1;
    end
  end
  // Clip bounds over all outputs; ancillary words are exempt
  always_comb begin
    okb = 1'b1;
    okw = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (!out_data[i].anc && out_data[i].data < 10'h040) okb = 1'b0;
      if (!out_data[i].anc && out_data[i].data > 10'h3ac) okw = 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ref_follow: assert property (1'b1 |=> frame_start == $past(selp))
    else $error("frame start not from chosen ref");
  a_clip_black: assert property (out_valid && clipb_q |-> okb)
    else $error("sample below black");
  a_clip_white: assert property (out_valid && clipw_q |-> okw)
    else $error("sample above white");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output dropped under stall");
  a_save_time: assert property (nv_save |-> dirty_q && cnt_q >= SAVE_CYC && cnt_q <= SAVE_CYC + 1)
    else $error("commit at wrong time");
  a_save_late: assert property (dirty_q |-> cnt_q <= SAVE_CYC + 1)
    else $error("commit overdue");
  a_fmt_check: assert property (fmt_ok == compat(ref_fmt[sel_q], req_q))
    else $error("format compatibility wrong");
  a_fmt_apply: assert property (fmt_ok |=> out_fmt == $past(req_q))
    else $error("format not applied");
  c_save: cover property (nv_save);
  c_stall: cover property (out_valid && !out_ready);
  c_fmt_bad: cover property (!fmt_ok);
endmodule // vorcd_props
`default_nettype wire

/* dv/vorcd_ref_model.sv */
`default_nettype none
// Sync references and the output sink
module vorcd_ref_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0][2:0] fmt_set,
  input wire logic [1:0] sink_mode,
  output logic [2:0] ref_pulse,
  output logic [2:0][2:0] ref_fmt,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Periods differ so a wrong reference pick shows; sink ready, random or stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      ref_pulse <= 3'h0;
      out_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ref_pulse <= {cnt_q % 4'h7 == 4'h0, cnt_q % 4'h5 == 4'h0, cnt_q[1:0] == 2'h0};
      out_ready <= sink_mode == 2'h0 ? 1'b1 : sink_mode == 2'h1 ? 1'($urandom) : 1'b0;
    end
  end
  // Detected formats are levels
  assign ref_fmt = fmt_set;
endmodule // vorcd_ref_model
`default_nettype wire

/* dv/vorcd_top_tb.sv */
`default_nettype none
module vorcd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {vorcd_pkg::vorcd_smp_t [3:0] s; logic [3:0] m;} vorcd_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, in_ready, out_valid, out_ready, frame_start, fmt_ok, nv_save, clipb, clipw;
  logic [2:0] ref_pulse, cur, req;
  logic [2:0][2:0] ref_fmt, fmt_set = '0;
  logic [1:0] sink_mode = 2'h1;
  logic [3:0] mask;
  logic [2:0] route [4];
  vorcd_pkg::vorcd_bundle_t in_data = '0;
  vorcd_pkg::vorcd_smp_t [3:0] out_data;
  vorcd_pkg::vorcd_fmt_t out_fmt;
  int err_count = 0, compares = 0, n, dith_hits = 0;
  vorcd_exp_t exp_q[$];
  // 125 MHz
  initial forever #4 pclk = ~pclk;
  vorcd_top #(.SAVE_CYC(32'd20)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .ref_pulse(ref_pulse), .ref_fmt(ref_fmt),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .frame_start(frame_start),
    .out_fmt(out_fmt), .fmt_ok(fmt_ok), .nv_save(nv_save));
  vorcd_ref_model u_ref (.pclk(pclk), .presetn(presetn), .fmt_set(fmt_set), .sink_mode(sink_mode),
    .ref_pulse(ref_pulse), .ref_fmt(ref_fmt), .out_ready(out_ready));
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tmo();
    chk("wait bound", 1, 0);
    wrap_up();
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) tmo();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] e, logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rdat);
    chk("pslverr", ee, rerr);
  endtask
  function automatic logic compat(logic [2:0] r, logic [2:0] o);
    case (r)
      3'h0, 3'h2: return o < 3'h3;
      3'h3, 3'h5: return o > 3'h2 && o < 3'h6;
      default: return o == r;
    endcase
  endfunction
  // Expected centre value of one output sample
  function automatic vorcd_pkg::vorcd_smp_t xsmp(vorcd_pkg::vorcd_smp_t s, logic q);
    if (s.anc) return q ? 11'h040 : s;
    if (s.data < 10'h004) s.data = 10'h004;
    if (s.data > 10'h3fb) s.data = 10'h3fb;
    if (clipb && s.data < 10'h040) s.data = 10'h040;
    if (clipw && s.data > 10'h3ac) s.data = 10'h3ac;
    return s;
  endfunction
  // Random bundles; a note per accepted bundle
  task automatic snd(int k, int lo, int span);
    vorcd_pkg::vorcd_bundle_t b;
    vorcd_pkg::vorcd_smp_t s;
    vorcd_exp_t e;
    repeat (k) begin
      for (int j = 0; j < 5; j++) begin
        s.anc = $urandom % 4 == 0;
        s.data = 10'(lo + $urandom % span);
        if (j == 4) b.quad = s;
        else b.bkgd[j] = s;
      end
      for (int i = 0; i < 4; i++) e.s[i] = xsmp(route[i] == 3'h0 ? b.quad : b.bkgd[route[i] - 3'h1], route[i] == 3'h0);
      e.m = mask;
      in_valid <= 1'b1;
      in_data <= b;
      for (n = 0; n < 50; n++) begin
        @(posedge pclk);
        if (in_ready === 1'b1) break;
      end
      if (n == 50) tmo();
      exp_q.push_back(e);
    end
    in_valid <= 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge pclk);
    if (exp_q.size() != 0) tmo();
  endtask
  // Each delivered bundle against the oldest note; dither gives a window
  always @(posedge pclk) begin
    vorcd_exp_t x;
    logic [10:0] d;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra bundle", 0, 1);
      else begin
        x = exp_q.pop_front();
        for (int i = 0; i < 4; i++) begin
          d = 11'(out_data[i].data) - 11'(x.s[i].data) + 11'(x.m >> 1);
          chk("anc", x.s[i].anc, out_data[i].anc);
          chk("sample", 1, x.s[i].anc ? out_data[i] === x.s[i] : d <= 11'(x.m));
          if (!x.s[i].anc && x.m != 4'h0 && d != 11'(x.m >> 1)) dith_hits++;
        end
      end
    end
  end
  initial begin
    void'($urandom(32'hae5b3c3f));
    route = '{default: 3'h0};
    {clipb, clipw, mask, cur, req} = {2'h0, 4'h0, 3'h2, 3'h2};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Defaults, then an unmapped word
    rdchk(12'h000, 32'h0, 1'b0);
    rdchk(12'h004, 32'h0, 1'b0);
    rdchk(12'h008, 32'h2, 1'b0);
    rdchk(12'h010, 32'h0, 1'b1);
    // Every source on every output, full-range data
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 4; i++) route[i] = 3'((i + k) % 5);
      apb(1'b1, 12'h000, {16'h0, 1'b0, route[3], 1'b0, route[2], 1'b0, route[1], 1'b0, route[0]});
      snd(6, 0, 1024);
      drain();
    end
    // All clip combinations
    for (int k = 0; k < 4; k++) begin
      {clipw, clipb} = 2'(k);
      apb(1'b1, 12'h004, 32'(k << 4));
      snd(6, 0, 1024);
      drain();
    end
    {clipw, clipb} = 2'h0;
    // Each dither depth, mid-range picture
    for (int k = 0; k < 4; k++) begin
      mask = k == 0 ? 4'h0 : 4'((2 << k) - 1);
      apb(1'b1, 12'h004, 32'(k));
      dith_hits = 0;
      snd(6, 256, 512);
      drain();
      if (k != 0) chk("dither used", 1, dith_hits != 0);
    end
    mask = 4'h0;
    apb(1'b1, 12'h004, 32'h0);
    // Stalled sink: eight queued plus one held, then refusal
    sink_mode <= 2'h2;
    @(posedge pclk);
    snd(9, 256, 512);
    @(posedge pclk);
    chk("in_ready", 0, in_ready);
    sink_mode <= 2'h1;
    drain();
    // Every reference format against every requested format
    for (int r = 0; r < 8; r++) begin
      fmt_set[r % 3] <= 3'(r);
      apb(1'b1, 12'h004, 32'((r % 3) << 8));
      if (compat(3'(r), req)) cur = req;
      for (int o = 0; o < 8; o++) begin
        req = 3'(o);
        apb(1'b1, 12'h008, 32'(o));
        if (compat(3'(r), req)) cur = req;
        rdchk(12'h00c, {17'h0, 3'(r), 4'h1, 3'h0, compat(3'(r), req), 1'b0, cur}, 1'b0);
        chk("fmt_ok", compat(3'(r), req), fmt_ok);
        chk("out_fmt", cur, out_fmt);
      end
    end
    // Commit follows the last change
    apb(1'b1, 12'h008, 32'(req));
    for (n = 0; n < 60 && nv_save !== 1'b1; n++) @(posedge pclk);
    chk("save delay", 1, n == 19 || n == 20);
    wrap_up();
  end
endmodule // vorcd_top_tb
bind vorcd_top vorcd_props #(.SAVE_CYC(SAVE_CYC)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .ref_pulse(ref_pulse), .ref_fmt(ref_fmt),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .frame_start(frame_start),
  .out_fmt(out_fmt), .fmt_ok(fmt_ok), .nv_save(nv_save));
`default_nettype wire
